// File: verilog/ext_irq_pkg.sv
// shared constants and carrier types for the upper external interrupt block
package ext_irq_pkg;

    // ========================================================================
    // bus geometry
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned PIN_N = 4;

    // ========================================================================
    // register byte addresses, one aligned word each
    localparam logic [ADDR_W-1:0] SENSE_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] MASK_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] GIE_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] STAT_OFS = 8'h0c;
    localparam logic [ADDR_W-1:0] IEN_OFS = 8'h10;
    localparam logic [ADDR_W-1:0] PIN_OFS = 8'h14;

    // ========================================================================
    // reset values and field positions
    localparam logic [7:0] SENSE_RST = 8'h00;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic GIE_RST = 1'b0;
    localparam logic [3:0] STAT_RST = 4'h0;
    localparam logic [3:0] IEN_RST = 4'h0;
    localparam logic [3:0] SYNC_RST = 4'hf;
    localparam int unsigned MASK_UPPER_LSB = 4;
    localparam int unsigned GIE_BIT = 0;
    localparam int unsigned STAT_LSB = 0;
    localparam int unsigned PIN_LSB = 4;

    // ========================================================================
    // sense select encodings, two bits per pin
    typedef enum logic [1:0] {
        SENSE_LOW = 2'b00,
        SENSE_ANY = 2'b01,
        SENSE_FALL = 2'b10,
        SENSE_RISE = 2'b11
    } sense_t;

    // ========================================================================
    // apb request and answer bundles
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
        logic [3:0] pstrb;
    } apb_req_t;

    typedef struct packed {
        logic [DATA_W-1:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;

    // synchronised pin samples handed from the sampler to the core
    typedef struct packed {
        logic [PIN_N-1:0] cur;
        logic [PIN_N-1:0] prev;
    } sample_t;

endpackage : ext_irq_pkg

// File: verilog/pin_sense_unit.sv
// pin synchroniser, successive-sample store and per-pin sense decoder
module pin_sense_unit (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [ext_irq_pkg::PIN_N-1:0] pins,
    input wire logic [7:0] sense,
    output logic [ext_irq_pkg::PIN_N-1:0] hit,
    output ext_irq_pkg::sample_t smp
);
    import ext_irq_pkg::*;

    typedef struct packed {
        logic [PIN_N-1:0] meta;
        logic [PIN_N-1:0] cur;
        logic [PIN_N-1:0] prev;
    } sync_state_t;

    sync_state_t st_r;
    sync_state_t st_nxt;

    // ========================================================================
    // sense decode, one call per pin
    function automatic logic sense_hit(input logic [1:0] sel,
                                       input logic c, input logic p);
        logic r;
        r = 1'b0;
        unique case (sense_t'(sel))
            SENSE_LOW: r = ~c;
            SENSE_ANY: r = c ^ p;
            SENSE_FALL: r = p & ~c;
            SENSE_RISE: r = c & ~p;
        endcase
        return r;
    endfunction : sense_hit

    // ========================================================================
    // idle-high reset so a pin held high at start-up never looks like a fall
    always_comb begin
        st_nxt = st_r;
        st_nxt.meta = pins;
        st_nxt.cur = st_r.meta;
        st_nxt.prev = st_r.cur;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= {SYNC_RST, SYNC_RST, SYNC_RST};
        end else begin
            st_r <= st_nxt;
        end
    end

    // compare the two newest samples, never the raw pin
    always_comb begin
        for (int i = 0; i < PIN_N; i++) begin
            hit[i] = sense_hit(sense[2*i +: 2], st_r.cur[i], st_r.prev[i]);
        end
    end

    assign smp.cur = st_r.cur;
    assign smp.prev = st_r.prev;

endmodule : pin_sense_unit

// File: verilog/ext_irq_sense_upper.sv
// apb register file, request gating and interrupt flags for pins 7 to 4
// How it works
// - request needs global enable and pin mask
// - edges found by comparing successive clocked samples
// - pulses over one clock are always caught
// - low level requests continuously while pin low
// - sense codes: low, any, falling, rising
// - sense register eight bits, read/write, resets zero
// - mask register eight bits, bit n pin n
//
// Added by the designer: the register offsets and register access over APB.
module ext_irq_sense_upper (
    input wire logic pclk,
    input wire logic presetn,
    input wire ext_irq_pkg::apb_req_t apb_req,
    output ext_irq_pkg::apb_rsp_t apb_rsp,
    input wire logic [ext_irq_pkg::PIN_N-1:0] upper_ext_irq_pins,
    output logic [ext_irq_pkg::PIN_N-1:0] ext_irq_req,
    output logic irq
);
    import ext_irq_pkg::*;

    // ========================================================================
    // state of the block
    typedef struct packed {
        logic [7:0] sense;
        logic [7:0] mask;
        logic gie;
        logic [PIN_N-1:0] status;
        logic [PIN_N-1:0] ien;
        logic [PIN_N-1:0] req;
        logic irq;
        logic [DATA_W-1:0] prdata;
        logic pready;
        logic pslverr;
    } core_state_t;

    localparam core_state_t CORE_RST = '{
        sense: SENSE_RST,
        mask: MASK_RST,
        gie: GIE_RST,
        status: STAT_RST,
        ien: IEN_RST,
        req: 4'h0,
        irq: 1'b0,
        prdata: 32'h0000_0000,
        pready: 1'b0,
        pslverr: 1'b0
    };

    core_state_t st_r;
    core_state_t st_nxt;

    logic [PIN_N-1:0] hit;
    sample_t smp;
    logic [PIN_N-1:0] en_upper;
    logic setup_phase;
    logic wr_take;
    logic [PIN_N-1:0] ev;
    logic [PIN_N-1:0] clr;

    // ========================================================================
    // sampler and sense decoder
    pin_sense_unit u_sense (
        .pclk(pclk),
        .presetn(presetn),
        .pins(upper_ext_irq_pins),
        .sense(st_r.sense),
        .hit(hit),
        .smp(smp)
    );

    // ========================================================================
    // address decode and read mux
    function automatic logic addr_known(input logic [ADDR_W-1:0] a);
        return (a == SENSE_OFS) || (a == MASK_OFS) || (a == GIE_OFS) ||
               (a == STAT_OFS) || (a == IEN_OFS) || (a == PIN_OFS);
    endfunction : addr_known

    function automatic logic [DATA_W-1:0] read_word(
            input logic [ADDR_W-1:0] a, input core_state_t s,
            input logic [PIN_N-1:0] lvl);
        logic [DATA_W-1:0] d;
        d = 32'h0000_0000;
        unique case (a)
            SENSE_OFS: d[7:0] = s.sense;
            MASK_OFS: d[7:0] = s.mask;
            GIE_OFS: d[GIE_BIT] = s.gie;
            STAT_OFS: d[STAT_LSB +: PIN_N] = s.status;
            IEN_OFS: d[STAT_LSB +: PIN_N] = s.ien;
            PIN_OFS: d[PIN_LSB +: PIN_N] = lvl;
            default: d = 32'h0000_0000;
        endcase
        return d;
    endfunction : read_word

    // ========================================================================
    // gating terms; only the upper half of the mask acts here
    always_comb begin
        en_upper = {PIN_N{st_r.gie}} & st_r.mask[MASK_UPPER_LSB +: PIN_N];
        ev = hit & en_upper;
        setup_phase = apb_req.psel & ~apb_req.penable;
        // a write lands only on the edge that sees pready high
        wr_take = apb_req.psel & apb_req.penable & apb_req.pwrite &
                  st_r.pready & apb_req.pstrb[0] &
                  addr_known(apb_req.paddr);
        clr = (wr_take && apb_req.paddr == STAT_OFS) ?
              apb_req.pwdata[STAT_LSB +: PIN_N] : 4'h0;
    end

    // ========================================================================
    // next state: bus answer, register writes, flags and request outputs
    always_comb begin
        st_nxt = st_r;
        // no wait state: pready rises for the first access cycle only
        st_nxt.pready = setup_phase;
        st_nxt.pslverr = setup_phase & ~addr_known(apb_req.paddr);
        if (setup_phase && !apb_req.pwrite) begin
            st_nxt.prdata = read_word(apb_req.paddr, st_r, smp.cur);
        end
        if (wr_take) begin
            unique case (apb_req.paddr)
                SENSE_OFS: st_nxt.sense = apb_req.pwdata[7:0];
                MASK_OFS: st_nxt.mask = apb_req.pwdata[7:0];
                GIE_OFS: st_nxt.gie = apb_req.pwdata[GIE_BIT];
                IEN_OFS: st_nxt.ien = apb_req.pwdata[STAT_LSB +: PIN_N];
                default: st_nxt.gie = st_r.gie;
            endcase
        end
        // level sense keeps hit high, so the request stays up while low
        st_nxt.req = ev;
        // a new event beats a write-one-to-clear in the same cycle
        st_nxt.status = (st_r.status & ~clr) | ev;
        st_nxt.irq = |(st_nxt.status & st_nxt.ien);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= CORE_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from the state register
    assign apb_rsp.prdata = st_r.prdata;
    assign apb_rsp.pready = st_r.pready;
    assign apb_rsp.pslverr = st_r.pslverr;
    assign ext_irq_req = st_r.req;
    assign irq = st_r.irq;

    // ========================================================================
    // checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // helper: skip the first cycles whose past values predate reset
    logic [1:0] warm_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            warm_r <= 2'h0;
        end else if (warm_r != 2'h3) begin
            warm_r <= warm_r + 2'h1;
        end
    end

    logic cfg_any0;
    logic cfg_low0;
    logic cfg_fall0;
    logic cfg_rise0;
    assign cfg_any0 = en_upper[0] && st_r.sense[1:0] == SENSE_ANY;
    assign cfg_low0 = en_upper[0] && st_r.sense[1:0] == SENSE_LOW;
    assign cfg_fall0 = en_upper[0] && st_r.sense[1:0] == SENSE_FALL;
    assign cfg_rise0 = en_upper[0] && st_r.sense[1:0] == SENSE_RISE;

    sequence pin_change_held;
        cfg_any0 && $changed(upper_ext_irq_pins[0])
        ##1 cfg_any0 && $stable(upper_ext_irq_pins[0]);
    endsequence

    sequence sense_write;
        apb_req.psel && !apb_req.penable && apb_req.pwrite &&
        apb_req.paddr == SENSE_OFS && apb_req.pstrb[0]
        ##1 apb_req.penable && $stable(apb_req.paddr) && $stable(apb_req.pwdata);
    endsequence

    gate_needs_enable_a: assert property (
        (ext_irq_req & ~$past(en_upper)) == 4'h0)
        else $error("request raised while pin or global enable clear");

    sync_latency_a: assert property (
        warm_r == 2'h3 |-> smp.cur == $past(upper_ext_irq_pins, 2))
        else $error("synchronised sample not two cycles behind pin");

    any_change_caught_a: assert property (
        pin_change_held |-> ##[1:3] (ext_irq_req[0] || !cfg_any0))
        else $error("held pin change missed in any-change sense");

    rise_edge_compare_a: assert property (
        cfg_rise0 && smp.cur[0] && !smp.prev[0] |=> ext_irq_req[0])
        else $error("rising edge between samples not requested");

    fall_decode_a: assert property (
        cfg_fall0 |=> ext_irq_req[0] == $past(smp.prev[0] & ~smp.cur[0]))
        else $error("falling sense decoded wrongly");

    rise_no_fall_a: assert property (
        cfg_rise0 && !(smp.cur[0] && !smp.prev[0]) |=> !ext_irq_req[0])
        else $error("rising sense fired without a rising edge");

    low_level_hold_a: assert property (
        (cfg_low0 && !smp.cur[0]) [*2] |-> ext_irq_req[0] ##1 ext_irq_req[0])
        else $error("low level request not held continuously");

    sense_store_a: assert property (
        sense_write ##0 st_r.pready |=>
            st_r.sense == $past(apb_req.pwdata[7:0]))
        else $error("sense register did not take written byte");

    mask_store_a: assert property (
        wr_take && apb_req.paddr == MASK_OFS |=>
            st_r.mask == $past(apb_req.pwdata[7:0]))
        else $error("mask register did not take written byte");

    flag_set_wins_a: assert property (
        ev[0] && clr[0] |=> st_r.status[0] && irq == |(st_r.status & st_r.ien))
        else $error("event lost against clear or irq out of step");

    ready_one_cycle_a: assert property (
        apb_req.psel && !apb_req.penable |=> apb_rsp.pready ##1 !apb_rsp.pready)
        else $error("pready not a single cycle after setup");

    // ========================================================================
    // bus refusals: errors ride with ready, refused writes change nothing
    sequence refused_write;
        apb_req.psel && apb_req.penable && apb_req.pwrite && apb_rsp.pready &&
        (!addr_known(apb_req.paddr) || !apb_req.pstrb[0]);
    endsequence

    unmapped_error_a: assert property (
        apb_req.psel && !apb_req.penable && !addr_known(apb_req.paddr) |=>
            apb_rsp.pready && apb_rsp.pslverr)
        else $error("unmapped address answered without error");

    mapped_no_error_a: assert property (
        apb_req.psel && !apb_req.penable && addr_known(apb_req.paddr) |=>
            apb_rsp.pready && !apb_rsp.pslverr)
        else $error("mapped address answered with error");

    unmapped_read_zero_a: assert property (
        apb_req.psel && !apb_req.penable && !apb_req.pwrite &&
        !addr_known(apb_req.paddr) |=> apb_rsp.prdata == 32'h0000_0000)
        else $error("unmapped read returned nonzero data");

    ready_after_setup_a: assert property (
        apb_rsp.pready |-> $past(apb_req.psel && !apb_req.penable))
        else $error("pready without a setup cycle before it");

    error_with_ready_a: assert property (
        apb_rsp.pslverr |-> apb_rsp.pready)
        else $error("slave error outside the ready cycle");

    // read data must stand until the next read setup replaces it
    prdata_holds_a: assert property (
        !(apb_req.psel && !apb_req.penable && !apb_req.pwrite) |=>
            $stable(apb_rsp.prdata))
        else $error("read data changed without a read setup");

    refused_no_write_a: assert property (
        refused_write |=> $stable(st_r.sense) && $stable(st_r.mask) &&
            $stable(st_r.gie) && $stable(st_r.ien))
        else $error("refused write changed a register");

    // ========================================================================
    // flags: set only by enabled events, sticky until a one is written
    gie_blocks_flag_a: assert property (
        !st_r.gie |=> (st_r.status & ~$past(st_r.status)) == 4'h0)
        else $error("flag set while global enable clear");

    mask_blocks_flag_a: assert property (
        (st_r.status & ~$past(st_r.status) & ~$past(en_upper)) == 4'h0)
        else $error("flag set for a masked pin");

    flag_sticky_a: assert property (
        st_r.status[0] && !clr[0] |=> st_r.status[0])
        else $error("flag cleared without a write of one");

    req_sets_flag_a: assert property (
        ext_irq_req[0] |-> st_r.status[0])
        else $error("request raised without its flag");

    any_decode_a: assert property (
        ext_irq_req[0] && $past(cfg_any0) |->
            $past(smp.cur[0] ^ smp.prev[0]))
        else $error("any-change request without a change");

    // irq follows the enabled flags in the same clock, writes aside
    irq_level_a: assert property (
        |(st_r.status & st_r.ien) && !wr_take |=> irq)
        else $error("interrupt low while an enabled flag is set");

    irq_quiet_a: assert property (
        !(|(st_r.status & st_r.ien)) && ev == 4'h0 && !wr_take |=> !irq)
        else $error("interrupt high with no enabled flag");

endmodule : ext_irq_sense_upper

// File: sim/pin_source.sv
// off-chip source model driving the four upper interrupt pins
module pin_source (
    input wire logic pclk,
    input wire logic [3:0] want,
    output logic [3:0] pins
);
    timeunit 1ns;
    timeprecision 1ns;

    // ========================================================================
    // level driver
    // levels move only just after an edge, so each lasts whole clocks
    initial pins = 4'hf;
    always @(posedge pclk) begin
        pins <= want;
    end
endmodule : pin_source

// File: sim/testbench.sv
// self-checking bench for the upper external interrupt block
module testbench;
    import ext_irq_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct packed {
        logic [7:0] a;
        logic [31:0] wd;
        logic [31:0] exp;
        logic err;
    } row_t;

    logic pclk = 1'b0;
    logic presetn = 1'b0;
    apb_req_t req = '0;
    apb_rsp_t rsp;
    logic [3:0] want = 4'hf;
    logic [3:0] pins;
    logic [3:0] ext_irq_req;
    logic irq;
    int num_errors = 0;
    int comparisons = 0;
    int hits = 0;
    int hits_up = 0;
    logic [3:0] strb = 4'hf;
    logic [31:0] rd;
    logic er;
    row_t rows [8];
    int exp_hits [4] = '{2, 2, 1, 1};

    // ========================================================================
    // clock, design and pin source
    initial forever #20 pclk = ~pclk;
    ext_irq_sense_upper dut (.pclk(pclk), .presetn(presetn),
        .apb_req(req), .apb_rsp(rsp), .upper_ext_irq_pins(pins),
        .ext_irq_req(ext_irq_req), .irq(irq));
    pin_source src (.pclk(pclk), .want(want), .pins(pins));

    // request cycles: pin 4 apart, pins 5 to 7 together
    always @(posedge pclk) begin
        if (ext_irq_req[0] === 1'b1) hits <= hits + 1;
        if ((|ext_irq_req[3:1]) === 1'b1) hits_up <= hits_up + 1;
    end

    // ========================================================================
    // shared tasks
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // request held to the rising edge that sees pready; data taken there
    // no cycle count is assumed: only the watchdog ends a stuck wait
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        @(posedge pclk);
        req <= '{1'b1, 1'b0, w, a, d, strb};
        @(posedge pclk);
        req.penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        er = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask : xfer

    task automatic chk_irq(input logic e);
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        chk("irq", {31'h0, e}, {31'h0, irq});
    endtask : chk_irq

    // pins in pm low for len whole cycles, then back high and let settle
    task automatic pulse(input int len, input logic [3:0] pm);
        @(posedge pclk);
        hits = 0;
        hits_up = 0;
        want <= want & ~pm;
        repeat (len) @(posedge pclk);
        want <= 4'hf;
        repeat (10) @(posedge pclk);
    endtask : pulse

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : close_out

    // ========================================================================
    // watchdog, far beyond the few hundred cycles the tests take
    initial begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        close_out();
    end

    // ========================================================================
    // main sequence
    initial begin
        rows[0] = '{SENSE_OFS, 32'h1a5, 32'ha5, 1'b0};
        rows[1] = '{MASK_OFS, 32'h5c, 32'h5c, 1'b0};
        rows[2] = '{MASK_OFS, 32'ha3, 32'ha3, 1'b0};
        rows[3] = '{8'h30, 32'h11, 32'h0, 1'b1};
        rows[4] = '{SENSE_OFS, 32'h5a, 32'h5a, 1'b0};
        rows[5] = '{IEN_OFS, 32'hff, 32'h0f, 1'b0};
        rows[6] = '{PIN_OFS, 32'hff, 32'hf0, 1'b0};
        rows[7] = '{GIE_OFS, 32'hff, 32'h1, 1'b0};
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        xfer(1'b0, SENSE_OFS, 0);
        chk("sense reset", 32'h0, rd);
        xfer(1'b0, MASK_OFS, 0);
        chk("mask reset", 32'h0, rd);
        $display("test reset values done");
        // register rows: write, then read back with the error flag
        foreach (rows[i]) begin
            xfer(1'b1, rows[i].a, rows[i].wd);
            xfer(1'b0, rows[i].a, 0);
            chk("read data", rows[i].exp, rd);
            chk("slverr", {31'h0, rows[i].err}, {31'h0, er});
        end
        $display("test register rows done");
        // every sense code on pin 4 with a two-cycle low pulse
        xfer(1'b1, GIE_OFS, 1);
        xfer(1'b1, IEN_OFS, 32'hf);
        for (int m = 0; m < 4; m++) begin
            xfer(1'b1, MASK_OFS, 0);
            xfer(1'b1, SENSE_OFS, {24'h0, {4{m[1:0]}}});
            xfer(1'b1, STAT_OFS, 32'hf);
            xfer(1'b1, MASK_OFS, 32'hf0);
            pulse(2, 4'h1);
            chk("req cycles", exp_hits[m], hits);
            chk("req upper idle", 0, hits_up);
            xfer(1'b0, STAT_OFS, 0);
            chk("status", 32'h1, rd);
            xfer(1'b1, IEN_OFS, 0);
            chk_irq(1'b0);
            xfer(1'b1, IEN_OFS, 32'hf);
            chk_irq(1'b1);
            xfer(1'b1, STAT_OFS, 32'h1);
            chk_irq(1'b0);
        end
        $display("test sense codes done");
        // gating: global enable off, then only lower mask bits set
        xfer(1'b1, GIE_OFS, 0);
        pulse(3, 4'h1);
        chk("req gie off", 0, hits);
        xfer(1'b1, GIE_OFS, 1);
        xfer(1'b1, MASK_OFS, 32'h0f);
        pulse(3, 4'h1);
        chk("req mask off", 0, hits);
        xfer(1'b0, STAT_OFS, 0);
        chk("status gated", 32'h0, rd);
        $display("test gating done");
        // pin 7 alone on falling sense: its field and its mask bit
        xfer(1'b1, SENSE_OFS, 32'h80);
        xfer(1'b1, MASK_OFS, 32'h80);
        pulse(2, 4'h8);
        chk("req pin 4 idle", 0, hits);
        chk("req pins 5-7", 1, hits_up);
        xfer(1'b0, STAT_OFS, 0);
        chk("status pin 7", 32'h8, rd);
        xfer(1'b1, STAT_OFS, 32'hf);
        $display("test pin 7 done");
        // held low level: a clear written while low loses to the new event
        xfer(1'b1, MASK_OFS, 0);
        xfer(1'b1, SENSE_OFS, 0);
        xfer(1'b1, MASK_OFS, 32'hf0);
        want[0] <= 1'b0;
        repeat (6) @(posedge pclk);
        xfer(1'b1, STAT_OFS, 32'h1);
        xfer(1'b0, STAT_OFS, 0);
        chk("status held low", 32'h1, rd);
        chk_irq(1'b1);
        @(posedge pclk);
        want[0] <= 1'b1;
        repeat (6) @(posedge pclk);
        xfer(1'b1, STAT_OFS, 32'h1);
        xfer(1'b0, STAT_OFS, 0);
        chk("status released", 32'h0, rd);
        $display("test held low done");
        // a write with byte lane 0 off is dropped without an error
        strb = 4'he;
        xfer(1'b1, SENSE_OFS, 32'h33);
        strb = 4'hf;
        chk("strobe slverr", 32'h0, {31'h0, er});
        xfer(1'b0, SENSE_OFS, 0);
        chk("strobe dropped", 32'h0, rd);
        $display("test strobe done");
        // reset in mid-run clears the registers again
        xfer(1'b1, SENSE_OFS, 32'h77);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        xfer(1'b0, SENSE_OFS, 0);
        chk("sense after reset", 32'h0, rd);
        $display("test mid reset done");
        close_out();
    end
endmodule : testbench
